/* File: logic/pot_defines.svh */
// Constants for the protocol observer and trace trigger block.
`ifndef POT_DEFINES_SVH
`define POT_DEFINES_SVH

`define POT_ADDR_W        8
`define POT_OFS_OBS_STAT  8'h00
`define POT_OFS_ACC_ERR   8'h04
`define POT_OFS_FIRST_ERR 8'h08
`define POT_OFS_MASK      8'h0c
`define POT_OFS_CMD       8'h10
`define POT_OFS_TRC_MODE  8'h14
`define POT_OFS_TRC_TMO   8'h18
`define POT_OFS_TRC_STAT  8'h1c
`define POT_OFS_TRIG_PT   8'h20
`define POT_OFS_LINES     8'h24
`define POT_OFS_RO_START  8'h28
`define POT_OFS_RO_COUNT  8'h2c
`define POT_OFS_RO_DATA   8'h30
`define POT_OFS_SIG_SEL   8'h34
`define POT_OFS_SIG_INFO  8'h38
`define POT_OFS_BPL       8'h3c
`define POT_OFS_PAT_BASE  8'h40

`define POT_CMD_OBS_RUN   0
`define POT_CMD_OBS_STOP  1
`define POT_CMD_OBS_CLEAR 2
`define POT_CMD_TRC_RUN   3
`define POT_CMD_TRC_STOP  4

`define POT_ST_RUN        0
`define POT_ST_SYNC       1
`define POT_ST_ERR        2

`define POT_R_FRAME_0     0
`define POT_R_IRDY_0      2
`define POT_R_IRDY_1      3
`define POT_R_DEVSEL_0    7
`define POT_R_STOP_0      14
`define POT_R_PARITY_0    22

`define POT_DEPTH         32768
`define POT_PTR_W         15
`define POT_LINE_W        96
`define POT_WORDS         3
`define POT_BYTES_LINE    32'h0000000c
`define POT_POST_LINES    16'h4000
`define POT_HB_SHIFT      8
`define POT_PAT_W         64

`endif

/* File: logic/pot_pkg.sv */
// Types shared by the protocol observer and trace trigger block.
package pot_pkg;

	typedef enum logic [1:0]
	{
		pot_tr_idle = 2'b00,
		pot_tr_pre  = 2'b01,
		pot_tr_post = 2'b10
	} pot_trace_state_type;

endpackage

/* File: logic/pot_observer.sv */
// Protocol observer, trace trigger, qualifier and trace memory.
`timescale 1ns/1ps
`include "pot_defines.svh"

module pot_observer
	import pot_pkg::*;
(
	input  wire logic                   core_clk,
	input  wire logic                   sys_rst,
	input  wire logic                   clk_en,
	input  wire logic [`POT_ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]            reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [31:0]            reg_rdata,
	input  wire logic [31:0]            pci_ad,
	input  wire logic [3:0]             pci_cbe_n,
	input  wire logic                   pci_frame_n,
	input  wire logic                   pci_irdy_n,
	input  wire logic                   pci_trdy_n,
	input  wire logic                   pci_devsel_n,
	input  wire logic                   pci_stop_n,
	input  wire logic [9:0]             pci_misc,
	input  wire logic                   pci_lock_n,
	input  wire logic                   pci_par,
	input  wire logic [15:0]            ext_trig,
	input  wire logic [2:0]             bus_phase,
	input  wire logic                   master_active,
	input  wire logic                   target_active,
	input  wire logic                   master_locked,
	input  wire logic                   target_locked
);

	// Register file state.
	logic [31:0]               rule_mask;
	logic                      timeout_trigger_select;
	logic [15:0]               timeout_trigger_count;
	logic [31:0]               pat_reg [0:7];
	logic [4:0]                sig_sel;

	// Observer state.
	logic                      obs_running;
	logic                      obs_out_of_sync;
	logic                      obs_err_found;
	logic [31:0]               accumulated_rule_errors;
	logic [31:0]               first_rule_error;
	logic                      prev_frame_n;
	logic                      prev_irdy_n;
	logic                      prev_trdy_n;
	logic                      prev_stop_n;
	logic                      prev_parity;
	logic                      prev_par_check;

	// Trace state.
	pot_trace_state_type       trc_state;
	logic                      trc_triggered;
	logic [`POT_PTR_W-1:0]     wr_ptr;
	logic [15:0]               lines_captured;
	logic [`POT_PTR_W-1:0]     trig_point;
	logic [15:0]               post_count;
	logic [23:0]               hb_count;
	logic                      prev_stored;
	logic [`POT_PTR_W-1:0]     ro_line;
	logic [15:0]               ro_left;
	logic [1:0]                ro_word;
	logic [`POT_LINE_W-1:0]    trace_mem [0:`POT_DEPTH-1];

	// Address decode.
	wire hit_cmd   = reg_wr && (reg_addr == `POT_OFS_CMD);
	wire wr_mask   = reg_wr && (reg_addr == `POT_OFS_MASK);
	wire wr_mode   = reg_wr && (reg_addr == `POT_OFS_TRC_MODE);
	wire wr_tmo    = reg_wr && (reg_addr == `POT_OFS_TRC_TMO);
	wire wr_start  = reg_wr && (reg_addr == `POT_OFS_RO_START);
	wire wr_count  = reg_wr && (reg_addr == `POT_OFS_RO_COUNT);
	wire wr_sel    = reg_wr && (reg_addr == `POT_OFS_SIG_SEL);
	wire rd_data   = reg_rd && (reg_addr == `POT_OFS_RO_DATA);
	wire pat_hit   = (reg_addr[7:5] == 3'(`POT_OFS_PAT_BASE >> 5));
	wire obs_run   = hit_cmd && reg_wdata[`POT_CMD_OBS_RUN];
	wire obs_stop  = hit_cmd && reg_wdata[`POT_CMD_OBS_STOP];
	wire obs_clear = hit_cmd && reg_wdata[`POT_CMD_OBS_CLEAR];
	wire trc_run   = hit_cmd && reg_wdata[`POT_CMD_TRC_RUN];
	wire trc_stop  = hit_cmd && reg_wdata[`POT_CMD_TRC_STOP];

	// Captured line: fixed offsets for every traced signal.
	wire [`POT_LINE_W-1:0] bus_line = {19'h0, prev_stored, target_locked,
		master_locked, target_active, master_active, bus_phase, ext_trig,
		pci_par, pci_lock_n, pci_misc, pci_stop_n, pci_devsel_n, pci_trdy_n,
		pci_irdy_n, pci_frame_n, pci_cbe_n, pci_ad};

	// Protocol checks, one error bit per rule position.
	wire parity_now = ^{pci_ad, pci_cbe_n};
	logic [31:0] violation;
	always_comb
	begin
		violation = 32'h0;
		violation[`POT_R_FRAME_0] = !prev_frame_n && pci_frame_n &&
			pci_irdy_n;
		violation[`POT_R_IRDY_0] = prev_frame_n && !pci_frame_n &&
			prev_irdy_n && !pci_irdy_n;
		violation[`POT_R_IRDY_1] = !prev_irdy_n && pci_irdy_n &&
			prev_trdy_n && prev_stop_n;
		violation[`POT_R_DEVSEL_0] = !pci_trdy_n && pci_devsel_n;
		violation[`POT_R_STOP_0] = !pci_stop_n && pci_devsel_n;
		violation[`POT_R_PARITY_0] = prev_par_check &&
			(pci_par != prev_parity);
	end
	wire sync_lost = prev_frame_n && prev_irdy_n && pci_frame_n &&
		!pci_irdy_n;

	wire [31:0] new_err = obs_running ? (violation & ~rule_mask) : 32'h0;
	wire [31:0] acc_base   = obs_clear ? 32'h0 : accumulated_rule_errors;
	wire [31:0] first_base = obs_clear ? 32'h0 : first_rule_error;
	wire [31:0] next_acc   = acc_base | new_err;
	wire [31:0] next_first = (first_base == 32'h0) ? new_err : first_base;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			obs_running <= 1'b0;
			obs_out_of_sync <= 1'b0;
			obs_err_found <= 1'b0;
			accumulated_rule_errors <= 32'h0;
			first_rule_error <= 32'h0;
		end
		else if (clk_en)
		begin
			if (obs_run)
				obs_running <= 1'b1;
			else if (obs_stop || obs_clear)
				obs_running <= 1'b0;
			obs_out_of_sync <= (obs_out_of_sync && !obs_clear) ||
				(obs_running && sync_lost);
			obs_err_found <= (obs_err_found && !obs_clear) ||
				(new_err != 32'h0);
			accumulated_rule_errors <= next_acc;
			first_rule_error <= next_first;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			prev_frame_n <= 1'b1;
			prev_irdy_n <= 1'b1;
			prev_trdy_n <= 1'b1;
			prev_stop_n <= 1'b1;
			prev_parity <= 1'b0;
			prev_par_check <= 1'b0;
		end
		else if (clk_en)
		begin
			prev_frame_n <= pci_frame_n;
			prev_irdy_n <= pci_irdy_n;
			prev_trdy_n <= pci_trdy_n;
			prev_stop_n <= pci_stop_n;
			prev_parity <= parity_now;
			prev_par_check <= (prev_frame_n && !pci_frame_n) ||
				(!pci_irdy_n && !pci_trdy_n);
		end
	end

	// Software settings.
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			rule_mask <= 32'h0;
			timeout_trigger_select <= 1'b0;
			timeout_trigger_count <= 16'h0;
			sig_sel <= 5'h0;
		end
		else if (clk_en)
		begin
			if (wr_mask)
				rule_mask <= reg_wdata;
			if (wr_mode)
				timeout_trigger_select <= reg_wdata[0];
			if (wr_tmo)
				timeout_trigger_count <= reg_wdata[15:0];
			if (wr_sel)
				sig_sel <= reg_wdata[4:0];
		end
	end

	// Pattern words: trigger value, trigger care, qualifier value, care.
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1)
		begin : g_pat
			always_ff @(posedge core_clk)
			begin
				if (sys_rst)
					pat_reg[gi] <= 32'h0;
				else if (clk_en && reg_wr && pat_hit &&
					(reg_addr[4:2] == 3'(gi)))
					pat_reg[gi] <= reg_wdata;
			end
		end
	endgenerate

	wire [`POT_PAT_W-1:0] trig_val  = {pat_reg[1], pat_reg[0]};
	wire [`POT_PAT_W-1:0] trig_care = {pat_reg[3], pat_reg[2]};
	wire [`POT_PAT_W-1:0] qual_val  = {pat_reg[5], pat_reg[4]};
	wire [`POT_PAT_W-1:0] qual_care = {pat_reg[7], pat_reg[6]};
	wire [`POT_PAT_W-1:0] cmp_bits  = bus_line[`POT_PAT_W-1:0];
	wire trig_match = ((cmp_bits ^ trig_val) & trig_care) == 64'h0;
	wire qual_match = ((cmp_bits ^ qual_val) & qual_care) == 64'h0;

	wire hb_hit = (hb_count == {timeout_trigger_count, 8'h00}) &&
		!trig_match;
	wire fire = timeout_trigger_select ? hb_hit : trig_match;
	wire acquiring = (trc_state != pot_tr_idle);
	wire store_now = acquiring && qual_match && !trc_stop;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			trc_state <= pot_tr_idle;
			trc_triggered <= 1'b0;
			wr_ptr <= 15'h0;
			lines_captured <= 16'h0;
			trig_point <= 15'h0;
			post_count <= 16'h0;
			hb_count <= 24'h0;
			prev_stored <= 1'b0;
		end
		else if (clk_en)
		begin
			prev_stored <= store_now;
			if (store_now)
			begin
				wr_ptr <= wr_ptr + 15'h1;
				if (lines_captured != 16'h8000)
					lines_captured <= lines_captured + 16'h1;
			end
			if (trig_match || trc_state != pot_tr_pre)
				hb_count <= 24'h0;
			else
				hb_count <= hb_count + 24'h1;
			case (trc_state)
				pot_tr_idle:
				begin
					if (trc_run)
					begin
						trc_state <= pot_tr_pre;
						trc_triggered <= 1'b0;
						wr_ptr <= 15'h0;
						lines_captured <= 16'h0;
						post_count <= 16'h0;
						prev_stored <= 1'b0;
					end
				end
				pot_tr_pre:
				begin
					if (trc_stop)
						trc_state <= pot_tr_idle;
					else if (fire)
					begin
						trc_state <= pot_tr_post;
						trc_triggered <= 1'b1;
						trig_point <= wr_ptr;
					end
				end
				pot_tr_post:
				begin
					if (trc_stop)
						trc_state <= pot_tr_idle;
					else if (store_now)
					begin
						post_count <= post_count + 16'h1;
						if (post_count == `POT_POST_LINES - 16'h1)
							trc_state <= pot_tr_idle;
					end
				end
				default:
					trc_state <= pot_tr_idle;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (clk_en && store_now)
			trace_mem[wr_ptr] <= bus_line;
	end

	wire [`POT_LINE_W-1:0] ro_line_data = trace_mem[ro_line];
	wire [31:0] ro_word_data = (ro_word == 2'd0) ? ro_line_data[31:0] :
		(ro_word == 2'd1) ? ro_line_data[63:32] : ro_line_data[95:64];
	wire ro_avail = (ro_left != 16'h0);

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			ro_line <= 15'h0;
			ro_left <= 16'h0;
			ro_word <= 2'd0;
		end
		else if (clk_en)
		begin
			if (wr_start)
			begin
				ro_line <= reg_wdata[`POT_PTR_W-1:0];
				ro_word <= 2'd0;
			end
			else if (rd_data && ro_avail)
			begin
				if (ro_word == 2'd2)
				begin
					ro_word <= 2'd0;
					ro_line <= ro_line + 15'h1;
				end
				else
					ro_word <= ro_word + 2'd1;
			end
			if (wr_count)
				ro_left <= reg_wdata[15:0];
			else if (rd_data && ro_avail && ro_word == 2'd2)
				ro_left <= ro_left - 16'h1;
		end
	end

	function automatic logic [15:0] sig_info(input logic [4:0] sel);
		logic [7:0] pos;
		logic [7:0] len;
		pos = 8'h0;
		len = 8'h1;
		if (sel == 5'd0)
			len = 8'h20;
		else if (sel == 5'd1)
		begin
			pos = 8'h20;
			len = 8'h4;
		end
		else if (sel <= 5'd16)
			pos = 8'(sel) + 8'h22;
		else if (sel <= 5'd18)
			pos = 8'(sel) + 8'h22;
		else if (sel == 5'd19)
		begin
			pos = 8'h35;
			len = 8'h10;
		end
		else if (sel == 5'd20)
		begin
			pos = 8'h45;
			len = 8'h3;
		end
		else if (sel <= 5'd25)
			pos = 8'(sel) + 8'h33;
		else
			len = 8'h0;
		return {len, pos};
	endfunction

	wire [31:0] obs_status = {29'h0, obs_err_found, obs_out_of_sync,
		obs_running};
	wire [31:0] trace_state_word = {30'h0, trc_triggered, !acquiring};
	wire [2:0]  pat_idx = reg_addr[4:2];

	wire [31:0] next_rdata =
		!reg_rd ? 32'h0 :
		(reg_addr == `POT_OFS_OBS_STAT)  ? obs_status :
		(reg_addr == `POT_OFS_ACC_ERR)   ? accumulated_rule_errors :
		(reg_addr == `POT_OFS_FIRST_ERR) ? first_rule_error :
		(reg_addr == `POT_OFS_MASK)      ? rule_mask :
		(reg_addr == `POT_OFS_TRC_MODE)  ? {31'h0, timeout_trigger_select} :
		(reg_addr == `POT_OFS_TRC_TMO)   ? {16'h0, timeout_trigger_count} :
		(reg_addr == `POT_OFS_TRC_STAT)  ? trace_state_word :
		(reg_addr == `POT_OFS_TRIG_PT)   ? {17'h0, trig_point} :
		(reg_addr == `POT_OFS_LINES)     ? {16'h0, lines_captured} :
		(reg_addr == `POT_OFS_RO_START)  ? {17'h0, ro_line} :
		(reg_addr == `POT_OFS_RO_COUNT)  ? {16'h0, ro_left} :
		(reg_addr == `POT_OFS_RO_DATA)   ?
			(ro_avail ? ro_word_data : 32'h0) :
		(reg_addr == `POT_OFS_SIG_SEL)   ? {27'h0, sig_sel} :
		(reg_addr == `POT_OFS_SIG_INFO)  ? {16'h0, sig_info(sig_sel)} :
		(reg_addr == `POT_OFS_BPL)       ? `POT_BYTES_LINE :
		(pat_hit && reg_addr[1:0] == 2'b00) ? pat_reg[pat_idx] :
		32'h0;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			reg_rdata <= 32'h0;
		else if (clk_en)
			reg_rdata <= next_rdata;
	end

endmodule

/* File: dv/pot_observer_chk.sv */
// Assertions on the register port of the protocol observer block.
`timescale 1ns/1ps
`include "pot_defines.svh"

module pot_observer_chk
(
	input wire logic                   core_clk,
	input wire logic                   sys_rst,
	input wire logic                   clk_en,
	input wire logic [`POT_ADDR_W-1:0] reg_addr,
	input wire logic [31:0]            reg_wdata,
	input wire logic                   reg_wr,
	input wire logic                   reg_rd,
	input wire logic [31:0]            reg_rdata,
	input wire logic                   pci_frame_n,
	input wire logic                   pci_irdy_n
);
	wire logic wr_cmd = reg_wr && reg_addr == 8'h10;
	wire logic rd_st  = reg_rd && reg_addr == 8'h00;
	wire logic idle   = pci_frame_n && pci_irdy_n;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst || !clk_en);

	property p_idle_zero;
		!reg_rd |=> reg_rdata == 32'h0;
	endproperty
	a_idle_zero: assert property (p_idle_zero)
		else $error("read data not zero outside a read");

	property p_st_high;
		rd_st |=> reg_rdata[31:3] == 29'h0;
	endproperty
	a_st_high: assert property (p_st_high)
		else $error("unused status bits not zero");

	property p_bpl;
		reg_rd && reg_addr == 8'h3c |=> reg_rdata == 32'h0000000c;
	endproperty
	a_bpl: assert property (p_bpl)
		else $error("bytes per line wrong");

	property p_unmapped;
		reg_rd && reg_addr >= 8'h60 |=> reg_rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");

	property p_clear;
		wr_cmd && reg_wdata[2] && idle ##1 rd_st |=> reg_rdata == 32'h0;
	endproperty
	a_clear: assert property (p_clear)
		else $error("status not zero after clear");

	property p_run;
		wr_cmd && reg_wdata[0] && !reg_wdata[2] ##1 rd_st |=> reg_rdata[0];
	endproperty
	a_run: assert property (p_run)
		else $error("running bit not set after run");

	property p_stop;
		wr_cmd && reg_wdata[1] && !reg_wdata[0] ##1 rd_st |=> !reg_rdata[0];
	endproperty
	a_stop: assert property (p_stop)
		else $error("running bit set after stop");

	property p_sig;
		reg_wr && reg_addr == 8'h34 && reg_wdata == 32'h2
			##1 reg_rd && reg_addr == 8'h38
			|=> reg_rdata == 32'h00000124;
	endproperty
	a_sig: assert property (p_sig)
		else $error("frame position or width wrong");

	property p_tmo;
		reg_wr && reg_addr == 8'h18 ##1 reg_rd && reg_addr == 8'h18
			|=> reg_rdata == ($past(reg_wdata, 2) & 32'h0000ffff);
	endproperty
	a_tmo: assert property (p_tmo)
		else $error("timeout count readback wrong");

	c_run: cover property (wr_cmd && reg_wdata[0]);
	c_err: cover property (rd_st ##1 reg_rdata[2]);
	c_data: cover property (reg_rd && reg_addr == 8'h30);
endmodule

bind pot_observer pot_observer_chk i_chk
(
	.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.pci_frame_n(pci_frame_n), .pci_irdy_n(pci_irdy_n)
);

/* File: dv/pot_pci_agent.sv */
// Model of the PCI agents whose traffic the observer watches.
`timescale 1ns/1ps

module pot_pci_agent
(
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        play,
	input  wire logic [1:0]  kind,
	output logic      [31:0] pci_ad,
	output logic      [3:0]  pci_cbe_n,
	output logic             pci_par,
	output logic             pci_frame_n,
	output logic             pci_irdy_n,
	output logic             pci_trdy_n,
	output logic             pci_devsel_n,
	output logic             pci_stop_n,
	output logic             pci_lock_n
);
	logic [1:0]  step;
	logic [1:0]  mode;
	logic [31:0] count;

	// Kind 1 raises ready with the frame; kind 2 omits device select.
	// Kind 3 raises ready while the frame stays idle.
	assign pci_ad       = count;
	assign pci_cbe_n    = count[3:0];
	assign pci_frame_n  = !(step == 2'h1 && mode != 2'h3);
	assign pci_irdy_n   = !(step == 2'h2 || (step == 2'h1 && mode[0]));
	assign pci_trdy_n   = step != 2'h2;
	assign pci_devsel_n = !(step == 2'h2 && mode != 2'h2);
	assign pci_stop_n   = 1'b1;
	assign pci_lock_n   = 1'b1;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			step    <= 2'h0;
			mode    <= 2'h0;
			count   <= 32'h0;
			pci_par <= 1'b0;
		end
		else
		begin
			count   <= count + 32'h1;
			// Parity covers the previous clock's address and enables.
			pci_par <= ^{pci_ad, pci_cbe_n};
			if (play)
			begin
				step <= 2'h1;
				mode <= kind;
			end
			else if (step != 2'h0)
				step <= (step == 2'h2) ? 2'h0 : step + 2'h1;
		end
	end
endmodule

/* File: dv/test_pci_protocol_observer_trace.sv */
// Self-checking bench for the protocol observer and trace trigger block.
`timescale 1ns/1ps

module test_pci_protocol_observer_trace;
	logic        core_clk  = 1'b0;
	logic        sys_rst   = 1'b1;
	logic        clk_en    = 1'b1;
	logic [7:0]  reg_addr  = 8'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [31:0] reg_rdata;
	logic [31:0] ad;
	logic [3:0]  cbe_n;
	logic        par;
	logic        frame_n;
	logic        irdy_n;
	logic        trdy_n;
	logic        devsel_n;
	logic        stop_n;
	logic        lock_n;
	logic [15:0] ext_trig  = 16'h0;
	logic        play      = 1'b0;
	logic [1:0]  kind      = 2'h0;
	logic [31:0] q;
	int          errors    = 0;
	int          samples_checked = 0;

	always #12.5 core_clk = ~core_clk;

	always @(posedge core_clk)
		ext_trig <= ext_trig + 16'h1;

	pot_observer i_dut
	(
		.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pci_ad(ad),
		.pci_cbe_n(cbe_n), .pci_frame_n(frame_n), .pci_irdy_n(irdy_n),
		.pci_trdy_n(trdy_n), .pci_devsel_n(devsel_n), .pci_stop_n(stop_n),
		.pci_misc(10'h3ff), .pci_lock_n(lock_n), .pci_par(par),
		.ext_trig(ext_trig), .bus_phase(ext_trig[2:0]),
		.master_active(ext_trig[3]), .target_active(ext_trig[4]),
		.master_locked(ext_trig[5]), .target_locked(ext_trig[6])
	);

	pot_pci_agent i_agent
	(
		.core_clk(core_clk), .sys_rst(sys_rst), .play(play), .kind(kind),
		.pci_ad(ad), .pci_cbe_n(cbe_n), .pci_par(par),
		.pci_frame_n(frame_n), .pci_irdy_n(irdy_n), .pci_trdy_n(trdy_n),
		.pci_devsel_n(devsel_n), .pci_stop_n(stop_n), .pci_lock_n(lock_n)
	);

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge core_clk);
	endtask

	task automatic wr_rd(input logic [7:0] a, input logic [31:0] d,
		input logic [7:0] ra, output logic [31:0] r);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		rd(ra, r);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wr_rd(a, d, 8'h00, q);
	endtask

	task automatic do_play(input logic [1:0] k);
		kind <= k;
		play <= 1'b1;
		@(posedge core_clk);
		play <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask

	task automatic t_reset;
		rd(8'h00, q);
		chk("status", q, 32'h0);
		rd(8'h1c, q);
		chk("trace status", q, 32'h1);
		rd(8'h3c, q);
		chk("bytes per line", q, 32'h0000000c);
		rd(8'hfc, q);
		chk("unmapped", q, 32'h0);
	endtask

	task automatic t_freeze;
		clk_en <= 1'b0;
		wr(8'h0c, 32'hff);
		clk_en <= 1'b1;
		rd(8'h0c, q);
		chk("frozen mask", q, 32'h0);
	endtask

	task automatic t_run_stop;
		wr_rd(8'h10, 32'h1, 8'h00, q);
		chk("run", q, 32'h1);
		wr_rd(8'h10, 32'h2, 8'h00, q);
		chk("stop", q, 32'h0);
	endtask

	task automatic t_errors;
		wr(8'h10, 32'h1);
		do_play(2'h0);
		rd(8'h04, q);
		chk("clean transfer", q, 32'h0);
		do_play(2'h1);
		rd(8'h08, q);
		chk("first", q, 32'h4);
		rd(8'h00, q);
		chk("status", q, 32'h5);
		do_play(2'h2);
		rd(8'h08, q);
		chk("first kept", q, 32'h4);
		rd(8'h04, q);
		chk("accumulated", q, 32'h84);
		wr_rd(8'h10, 32'h2, 8'h04, q);
		chk("kept after stop", q, 32'h84);
		wr_rd(8'h10, 32'h4, 8'h00, q);
		chk("cleared status", q, 32'h0);
		rd(8'h08, q);
		chk("cleared first", q, 32'h0);
		wr(8'h10, 32'h1);
		do_play(2'h3);
		rd(8'h00, q);
		chk("out of sync", q, 32'h3);
		wr_rd(8'h10, 32'h4, 8'h00, q);
		chk("sync cleared", q, 32'h0);
	endtask

	task automatic t_mask;
		wr_rd(8'h0c, 32'h4, 8'h0c, q);
		chk("mask", q, 32'h4);
		wr(8'h10, 32'h1);
		do_play(2'h1);
		rd(8'h04, q);
		chk("masked", q, 32'h0);
		rd(8'h00, q);
		chk("masked status", q & 32'h5, 32'h1);
		wr(8'h10, 32'h4);
		wr(8'h0c, 32'h0);
	endtask

	task automatic t_trace;
		wr(8'h4c, 32'h10);
		wr(8'h5c, 32'h10);
		wr(8'h10, 32'h8);
		rd(8'h1c, q);
		chk("acquiring", q, 32'h0);
		do_play(2'h0);
		wr(8'h10, 32'h10);
		rd(8'h1c, q);
		chk("triggered", q, 32'h3);
		rd(8'h24, q);
		chk("lines", q, 32'h1);
		rd(8'h20, q);
		chk("trigger line", q, 32'h0);
		wr(8'h28, 32'h0);
		wr(8'h2c, 32'h1);
		rd(8'h30, q);
		rd(8'h30, q);
		chk("frame and ready", q & 32'h30, 32'h20);
		rd(8'h30, q);
		rd(8'h30, q);
		chk("count spent", q, 32'h0);
		wr_rd(8'h34, 32'h2, 8'h38, q);
		chk("frame info", q, 32'h00000124);
		wr_rd(8'h34, 32'h0, 8'h38, q);
		chk("ad info", q, 32'h00002000);
	endtask

	task automatic t_heartbeat;
		wr(8'h14, 32'h1);
		wr_rd(8'h18, 32'h1, 8'h18, q);
		chk("timeout count", q, 32'h1);
		wr(8'h10, 32'h8);
		repeat (200) @(posedge core_clk);
		rd(8'h1c, q);
		chk("no early fire", q, 32'h0);
		repeat (100) @(posedge core_clk);
		rd(8'h1c, q);
		chk("timeout fire", q & 32'h2, 32'h2);
		wr(8'h10, 32'h10);
	endtask

	task automatic report_and_stop;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		t_reset;
		t_freeze;
		t_run_stop;
		t_errors;
		t_mask;
		t_trace;
		t_heartbeat;
		report_and_stop;
	end

	initial
	begin
		repeat (20000) @(posedge core_clk);
		errors++;
		report_and_stop;
	end
endmodule
